// ===== hdl/thermal_readout_limit_registers.sv
// Result and limit registers of a remote/local temperature monitor with fan tach input.
// Assumes an SMBus front end giving one-cycle read and write strobes with an 8-bit address,
// and a converter that pulses convDone with a fresh raw remote and local sample.
`timescale 1ns/1ps
module thermal_readout_limit_registers
  import thermal_limits_pkg::*;
#(
  parameter int COUNT_W = 14
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdata_ff,
  input  wire logic        convDone,
  input  wire logic [7:0]  rawDieTemp,
  input  wire logic [12:0] rawRemoteTemp,
  input  wire logic        tachIn,
  input  wire logic        countTick,
  input  wire logic [1:0]  pulse_edge_select,
  input  wire logic        fastPwmClock,
  input  wire logic        unsigned_format_select,
  input  wire logic        extended_resolution_enable,
  input  wire logic        critOverride,
  input  wire logic        alarmClear,
  output logic             die_high_alarm,
  output logic             remote_upper_alarm,
  output logic             remote_lower_alarm,
  output logic             remote_critical_alarm,
  output logic             fanSlowAlarm,
  output logic             alertActive,
  output logic             critical_shutdown_pin,
  output logic             beta_comp_enable,
  output logic [1:0]       filter_level_select
);
  logic [7:0]         localTemp_ff;
  logic [12:0]        remoteTemp_ff;
  logic [7:0]         localHigh_ff;
  logic [10:0]        remoteHigh_ff;
  logic [10:0]        remoteLow_ff;
  logic [10:0]        offset_ff;
  logic [7:0]         critLimit_ff;
  logic               critLocked_ff;
  logic [6:0]         critHyst_ff;
  logic               betaEnable_ff;
  logic [1:0]         filterSel_ff;
  logic               cmpMode_ff;
  logic [COUNT_W-1:0] fanLimit_ff;
  logic [7:0]         fanHiFrozen_ff;
  logic [COUNT_W-1:0] periodCount;
  logic               periodValid;
  logic [4:0]         alarmLatch_ff;
  logic               critActive_ff;
  logic               convSeen_ff;
  logic [4:0]         latchMask;
  logic [13:0]        offsetSum;
  logic [12:0]        nxt_remoteTemp;
  logic [10:0]        remote11;
  logic [10:0]        critExt;
  logic [10:0]        critReleaseExt;
  logic               remAboveHigh;
  logic               remBelowLow;
  logic               remAboveCrit;
  logic               remBelowRelease;
  logic               dieAbove;
  logic [4:0]         liveCond;
  logic               filterOn;
  logic [1:0]         signedLow2;
  logic [1:0]         unsignedLow2;
  logic [7:0]         nxt_rdata;

  fan_edge_counter #(
    .COUNT_W (COUNT_W)
  ) u_fanCount (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .clkEn          (clkEn),
    .tachIn         (tachIn),
    .countTick      (countTick),
    .edgeSelect     (pulse_edge_select),
    .fastPwmClock   (fastPwmClock),
    .periodCount_ff (periodCount),
    .periodValid_ff (periodValid)
  );

  // Offset is added at eighth-degree weight; the two finest raw bits pass through
  assign offsetSum      = {rawRemoteTemp[12], rawRemoteTemp} + {offset_ff[10], offset_ff, 2'b00};
  assign nxt_remoteTemp = offsetSum[12:0];
  assign remote11       = remoteTemp_ff[12:2];
  assign filterOn       = filterSel_ff != FILTER_OFF;

  // Critical limit scaled to 11-bit reading format, fraction zero
  assign critExt        = {critLimit_ff, 3'b000};
  assign critReleaseExt = critExt - {1'b0, critHyst_ff, 3'b000};

  limit_compare #(.W(11)) u_cmpHigh (
    .valueIn      (remote11),
    .limitIn      (remoteHigh_ff),
    .unsignedMode (unsigned_format_select),
    .above        (remAboveHigh),
    .below        ()
  );
  limit_compare #(.W(11)) u_cmpLow (
    .valueIn      (remote11),
    .limitIn      (remoteLow_ff),
    .unsignedMode (1'b0),
    .above        (),
    .below        (remBelowLow)
  );
  limit_compare #(.W(11)) u_cmpCrit (
    .valueIn      (remote11),
    .limitIn      (critExt),
    .unsignedMode (unsigned_format_select),
    .above        (remAboveCrit),
    .below        ()
  );
  limit_compare #(.W(11)) u_cmpRelease (
    .valueIn      (remote11),
    .limitIn      (critReleaseExt),
    .unsignedMode (unsigned_format_select),
    .above        (),
    .below        (remBelowRelease)
  );
  limit_compare #(.W(8)) u_cmpDie (
    .valueIn      (localTemp_ff),
    .limitIn      (localHigh_ff),
    .unsignedMode (1'b0),
    .above        (dieAbove),
    .below        ()
  );

  assign liveCond = {dieAbove, remAboveHigh, remBelowLow, remAboveCrit, periodCount > fanLimit_ff};

  // Conversion results captured together so limits see one consistent sample
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      localTemp_ff  <= RST_ZERO;
      remoteTemp_ff <= '0;
    end else if (clkEn && convDone) begin
      localTemp_ff  <= rawDieTemp;
      remoteTemp_ff <= nxt_remoteTemp;
    end
  end

  // Compares see a new sample one cycle after convDone, so latching waits for it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      convSeen_ff <= 1'b0;
    end else if (clkEn) begin
      convSeen_ff <= convDone;
    end
  end

  // Temperature alarms latch per conversion, fan alarm per fan sample; set wins over clear
  assign latchMask = {{4{convSeen_ff}}, periodValid};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      alarmLatch_ff <= '0;
    end else if (clkEn) begin
      alarmLatch_ff <= (alarmClear ? liveCond : alarmLatch_ff) | (liveCond & latchMask);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      critActive_ff <= 1'b0;
    end else if (clkEn) begin
      if (remAboveCrit) begin
        critActive_ff <= 1'b1;
      end else if (remBelowRelease) begin
        critActive_ff <= 1'b0;
      end
    end
  end

  assign fanSlowAlarm          = alarmLatch_ff[0];
  assign remote_critical_alarm = alarmLatch_ff[1];
  assign remote_lower_alarm    = alarmLatch_ff[2];
  assign remote_upper_alarm    = alarmLatch_ff[3];
  assign die_high_alarm        = alarmLatch_ff[4];
  assign critical_shutdown_pin = critActive_ff;
  assign alertActive           = cmpMode_ff ? (|liveCond) : (|alarmLatch_ff);
  assign beta_comp_enable      = betaEnable_ff;
  assign filter_level_select   = filterSel_ff;

  // Host-writable limits and controls
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      localHigh_ff  <= RST_LOCAL_HIGH;
      remoteHigh_ff <= {RST_REM_HIGH_HI, 3'b000};
      remoteLow_ff  <= '0;
      offset_ff     <= '0;
      critLimit_ff  <= RST_CRIT_LIMIT;
      critLocked_ff <= 1'b0;
      critHyst_ff   <= RST_CRIT_HYST;
      betaEnable_ff <= RST_BETA_ENABLE;
      filterSel_ff  <= FILTER_OFF;
      cmpMode_ff    <= 1'b0;
      fanLimit_ff   <= '1;
    end else if (clkEn && regWrite) begin
      unique case (regAddr)
        ADDR_LOCAL_HIGH:   localHigh_ff <= regWdata;
        ADDR_REM_HIGH_HI:  remoteHigh_ff[10:3] <= regWdata;
        ADDR_REM_HIGH_LO:  remoteHigh_ff[2:0] <= regWdata[FRAC_MSB:FRAC_LSB];
        ADDR_REM_LOW_HI:   remoteLow_ff[10:3] <= regWdata;
        ADDR_REM_LOW_LO:   remoteLow_ff[2:0] <= regWdata[FRAC_MSB:FRAC_LSB];
        ADDR_OFFSET_HI:    offset_ff[10:3] <= regWdata;
        ADDR_OFFSET_LO:    offset_ff[2:0] <= regWdata[FRAC_MSB:FRAC_LSB];
        ADDR_CRIT_LIMIT: begin
          // Without override only the first write lands; later ones are dropped
          if (critOverride || !critLocked_ff) begin
            critLimit_ff  <= regWdata;
            critLocked_ff <= ~critOverride;
          end
        end
        ADDR_CRIT_HYST:    critHyst_ff <= regWdata[6:0];
        ADDR_BETA_COMP:    betaEnable_ff <= regWdata[BETA_BIT];
        ADDR_FILTER_MODE: begin
          filterSel_ff <= regWdata[FILTER_LSB+1:FILTER_LSB];
          cmpMode_ff   <= regWdata[CMP_MODE_BIT];
        end
        ADDR_FAN_LIMIT_HI: fanLimit_ff[COUNT_W-1:6] <= regWdata;
        ADDR_FAN_LIMIT_LO: fanLimit_ff[5:0] <= regWdata[7:2];
        default: ;
      endcase
    end
  end

  // Low byte read latches the high half so a 16-bit read is coherent
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fanHiFrozen_ff <= RST_FAN_LIMIT;
    end else if (clkEn && regRead && regAddr == ADDR_FAN_COUNT_LO) begin
      fanHiFrozen_ff <= periodCount[COUNT_W-1:6];
    end
  end

  // Extended resolution without filtering flags readings over 127.0 and any with the sign bit set
  assign signedLow2   = filterOn ? (extended_resolution_enable ? remoteTemp_ff[1:0] : 2'b00)
                      : ((extended_resolution_enable && !remoteTemp_ff[12] && remoteTemp_ff[11:5] == 7'h7f
                          && remoteTemp_ff[4:2] != 3'h0) || (extended_resolution_enable && remoteTemp_ff[12])
                          ? 2'b11 : 2'b00);
  assign unsignedLow2 = filterOn ? remoteTemp_ff[1:0] : 2'b00;

  always_comb begin
    nxt_rdata = RST_ZERO;
    unique case (regAddr)
      ADDR_LOCAL_TEMP:      nxt_rdata = localTemp_ff;
      ADDR_REM_SIGNED_HI:   nxt_rdata = remoteTemp_ff[12:5];
      ADDR_REM_SIGNED_LO:   nxt_rdata = {remoteTemp_ff[4:2], signedLow2, 3'b000};
      ADDR_REM_UNSIGNED_HI: nxt_rdata = remoteTemp_ff[12:5];
      ADDR_REM_UNSIGNED_LO: nxt_rdata = {remoteTemp_ff[4:2], unsignedLow2, 3'b000};
      ADDR_LOCAL_HIGH:      nxt_rdata = localHigh_ff;
      ADDR_REM_HIGH_HI:     nxt_rdata = remoteHigh_ff[10:3];
      ADDR_REM_HIGH_LO:     nxt_rdata = {remoteHigh_ff[2:0], 5'h00} & HI_FRAC_MASK;
      ADDR_REM_LOW_HI:      nxt_rdata = remoteLow_ff[10:3];
      ADDR_REM_LOW_LO:      nxt_rdata = {remoteLow_ff[2:0], 5'h00};
      ADDR_OFFSET_HI:       nxt_rdata = offset_ff[10:3];
      ADDR_OFFSET_LO:       nxt_rdata = {offset_ff[2:0], 5'h00};
      ADDR_CRIT_LIMIT:      nxt_rdata = critLimit_ff;
      ADDR_CRIT_HYST:       nxt_rdata = {1'b0, critHyst_ff};
      ADDR_BETA_COMP:       nxt_rdata = {6'h00, betaEnable_ff, 1'b0};
      ADDR_FILTER_MODE:     nxt_rdata = {5'h00, filterSel_ff, cmpMode_ff};
      ADDR_FAN_COUNT_LO:    nxt_rdata = {periodCount[5:0], pulse_edge_select} ;
      ADDR_FAN_COUNT_HI:    nxt_rdata = fanHiFrozen_ff;
      ADDR_FAN_LIMIT_HI:    nxt_rdata = fanLimit_ff[COUNT_W-1:6];
      ADDR_FAN_LIMIT_LO:    nxt_rdata = {fanLimit_ff[5:0], 2'b11} & FAN_LO_MASK | 8'h03;
      default:              nxt_rdata = RST_ZERO;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      regRdata_ff <= RST_ZERO;
    end else if (clkEn && regRead) begin
      regRdata_ff <= nxt_rdata;
    end
  end
endmodule // thermal_readout_limit_registers

// ===== shared/thermal_limits_pkg.sv
// Package: register map, field positions, reset values and encodings of the thermal readout block.
// Assumes an 8-bit register port driven by an SMBus front end outside this block.
package thermal_limits_pkg;
  localparam logic [7:0] ADDR_LOCAL_TEMP      = 8'h00;
  localparam logic [7:0] ADDR_REM_SIGNED_HI   = 8'h01;
  localparam logic [7:0] ADDR_LOCAL_HIGH      = 8'h05;
  localparam logic [7:0] ADDR_REM_HIGH_HI     = 8'h07;
  localparam logic [7:0] ADDR_REM_LOW_HI      = 8'h08;
  localparam logic [7:0] ADDR_REM_SIGNED_LO   = 8'h10;
  localparam logic [7:0] ADDR_OFFSET_HI       = 8'h11;
  localparam logic [7:0] ADDR_OFFSET_LO       = 8'h12;
  localparam logic [7:0] ADDR_REM_HIGH_LO     = 8'h13;
  localparam logic [7:0] ADDR_REM_LOW_LO      = 8'h14;
  localparam logic [7:0] ADDR_CRIT_LIMIT      = 8'h19;
  localparam logic [7:0] ADDR_CRIT_HYST       = 8'h21;
  localparam logic [7:0] ADDR_BETA_COMP       = 8'h30;
  localparam logic [7:0] ADDR_REM_UNSIGNED_HI = 8'h31;
  localparam logic [7:0] ADDR_REM_UNSIGNED_LO = 8'h32;
  localparam logic [7:0] ADDR_FAN_COUNT_LO    = 8'h46;
  localparam logic [7:0] ADDR_FAN_COUNT_HI    = 8'h47;
  localparam logic [7:0] ADDR_FAN_LIMIT_LO    = 8'h48;
  localparam logic [7:0] ADDR_FAN_LIMIT_HI    = 8'h49;
  localparam logic [7:0] ADDR_FILTER_MODE     = 8'hbf;

  localparam logic [7:0] RST_LOCAL_HIGH   = 8'h46;
  localparam logic [7:0] RST_REM_HIGH_HI  = 8'h55;
  localparam logic [7:0] RST_ZERO         = 8'h00;
  localparam logic [7:0] RST_FAN_LIMIT    = 8'hff;
  localparam logic [7:0] RST_CRIT_LIMIT   = 8'h6e;
  localparam logic [6:0] RST_CRIT_HYST    = 7'h0a;
  localparam logic       RST_BETA_ENABLE  = 1'b1;

  localparam int BETA_BIT       = 1;
  localparam int FILTER_LSB     = 1;
  localparam int CMP_MODE_BIT   = 0;
  localparam int FRAC_MSB       = 7;
  localparam int FRAC_LSB       = 5;
  localparam logic [7:0] HI_FRAC_MASK = 8'he0;
  localparam logic [7:0] FAN_LO_MASK  = 8'hfc;

  typedef enum logic [1:0] {
    EDGE_RESERVED = 2'h0,
    EDGE_TWO      = 2'h1,
    EDGE_THREE    = 2'h2,
    EDGE_FIVE     = 2'h3
  } edge_select_e;

  typedef enum logic [1:0] {
    FILTER_OFF  = 2'h0,
    FILTER_MIN1 = 2'h1,
    FILTER_MIN2 = 2'h2,
    FILTER_MAX  = 2'h3
  } filter_level_e;

  localparam logic [2:0] SCALE_FOUR = 3'h4;
  localparam logic [2:0] SCALE_TWO  = 3'h2;
  localparam logic [2:0] SCALE_ONE  = 3'h1;
endpackage

// ===== hdl/fan_edge_counter.sv
// Fan period counter: counts clock ticks over a chosen number of tach edges and scales the result.
// Assumes tach input synchronous to core_clk and a tick enable from outside.
`timescale 1ns/1ps
module fan_edge_counter
  import thermal_limits_pkg::*;
#(
  parameter int COUNT_W = 14
) (
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic               clkEn,
  input  wire logic               tachIn,
  input  wire logic               countTick,
  input  wire logic [1:0]         edgeSelect,
  input  wire logic               fastPwmClock,
  output logic      [COUNT_W-1:0] periodCount_ff,
  output logic                    periodValid_ff
);
  logic               tachPrev_ff;
  logic [2:0]         edgeCnt_ff;
  logic [COUNT_W+1:0] tickCnt_ff;
  logic [2:0]         edgesNeeded;
  logic [2:0]         scale;
  logic               tachEdge;
  logic [COUNT_W+3:0] scaled;

  assign tachEdge = tachIn & ~tachPrev_ff;

  always_comb begin
    unique case (edge_select_e'(edgeSelect))
      EDGE_TWO:   begin edgesNeeded = 3'h2; scale = SCALE_FOUR; end
      EDGE_THREE: begin edgesNeeded = 3'h3; scale = SCALE_TWO;  end
      EDGE_FIVE:  begin edgesNeeded = 3'h5; scale = SCALE_ONE;  end
      EDGE_RESERVED: begin edgesNeeded = 3'h2; scale = SCALE_FOUR; end
    endcase
    if (fastPwmClock) begin
      scale = SCALE_ONE;
    end
  end

  assign scaled = {2'b00, tickCnt_ff} * {{(COUNT_W+1){1'b0}}, scale};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tachPrev_ff    <= 1'b0;
      edgeCnt_ff     <= 3'h0;
      tickCnt_ff     <= '0;
      periodCount_ff <= '1;
      periodValid_ff <= 1'b0;
    end else if (clkEn) begin
      tachPrev_ff    <= tachIn;
      periodValid_ff <= 1'b0;
      if (tachEdge) begin
        if (edgeCnt_ff + 3'h1 >= edgesNeeded) begin
          // Saturate so a very slow fan reads full scale instead of wrapping
          periodCount_ff <= (|scaled[COUNT_W+3:COUNT_W]) ? '1 : scaled[COUNT_W-1:0];
          periodValid_ff <= 1'b1;
          edgeCnt_ff     <= 3'h1;
          tickCnt_ff     <= '0;
        end else begin
          edgeCnt_ff <= edgeCnt_ff + 3'h1;
        end
      end else if (countTick && edgeCnt_ff != 3'h0 && !(&tickCnt_ff)) begin
        tickCnt_ff <= tickCnt_ff + 1'b1;
      end
    end
  end
endmodule // fan_edge_counter

// ===== hdl/limit_compare.sv
// Signed or unsigned magnitude compare with greater-than and less-than outputs.
// Assumes both operands share one format chosen by the caller.
`timescale 1ns/1ps
module limit_compare #(
  parameter int W = 11
) (
  input  wire logic [W-1:0] valueIn,
  input  wire logic [W-1:0] limitIn,
  input  wire logic         unsignedMode,
  output logic              above,
  output logic              below
);
  logic [W:0] extValue;
  logic [W:0] extLimit;
  assign extValue = {~unsignedMode & valueIn[W-1], valueIn};
  assign extLimit = {~unsignedMode & limitIn[W-1], limitIn};
  assign above = $signed(extValue) > $signed(extLimit);
  assign below = $signed(extValue) < $signed(extLimit);
endmodule // limit_compare

// ===== testbench/thermal_readout_checker.sv
// Checker: port-level timing of register writes, read data and alarm outputs.
// Assumes clkEn held high and a one-cycle write strobe on the register port.
`timescale 1ns/1ps
module thermal_readout_checker
  import thermal_limits_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdata_ff,
  input wire logic       convDone,
  input wire logic       alarmClear,
  input wire logic       die_high_alarm,
  input wire logic       remote_upper_alarm,
  input wire logic       remote_critical_alarm,
  input wire logic       critical_shutdown_pin,
  input wire logic       beta_comp_enable,
  input wire logic [1:0] filter_level_select
);
  import thermal_limits_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_rdata_hold; !$past(regRead) |-> $stable(regRdata_ff); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
  property p_beta_rst; $rose(rst_n) |-> beta_comp_enable; endproperty
  a_beta_rst: assert property (p_beta_rst) else $error("beta enable not set after reset");
  property p_filt_rst; $rose(rst_n) |-> filter_level_select == 2'h0; endproperty
  a_filt_rst: assert property (p_filt_rst) else $error("filter not off after reset");
  property p_beta_wr;
    $past(regWrite && regAddr == ADDR_BETA_COMP) |-> beta_comp_enable == $past(regWdata[BETA_BIT]);
  endproperty
  a_beta_wr: assert property (p_beta_wr) else $error("beta enable not written");
  property p_filt_wr;
    $past(regWrite && regAddr == ADDR_FILTER_MODE) |-> filter_level_select == $past(regWdata[2:1]);
  endproperty
  a_filt_wr: assert property (p_filt_wr) else $error("filter field not written");
  // Alarms may only rise one or two cycles after a conversion; die alarm falls only after a clear, shutdown only after a conversion
  property p_die_rise; $rose(die_high_alarm) |-> $past(convDone) || $past(convDone, 2); endproperty
  a_die_rise: assert property (p_die_rise) else $error("die alarm set without conversion");
  property p_die_fall; $fell(die_high_alarm) |-> $past(alarmClear) || $past(alarmClear, 2); endproperty
  a_die_fall: assert property (p_die_fall) else $error("die alarm dropped without clear");
  property p_rem_rise; $rose(remote_upper_alarm) |-> $past(convDone) || $past(convDone, 2); endproperty
  a_rem_rise: assert property (p_rem_rise) else $error("remote alarm set without conversion");
  property p_crit_rise; $rose(remote_critical_alarm) |-> $past(convDone) || $past(convDone, 2); endproperty
  a_crit_rise: assert property (p_crit_rise) else $error("critical alarm set without conversion");
  property p_sd_fall; $fell(critical_shutdown_pin) |-> $past(convDone) || $past(convDone, 2); endproperty
  a_sd_fall: assert property (p_sd_fall) else $error("shutdown released without conversion");
endmodule // thermal_readout_checker

bind thermal_readout_limit_registers thermal_readout_checker u_thermal_readout_checker (
  .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .regRead(regRead), .regRdata_ff(regRdata_ff), .convDone(convDone), .alarmClear(alarmClear),
  .die_high_alarm(die_high_alarm), .remote_upper_alarm(remote_upper_alarm),
  .remote_critical_alarm(remote_critical_alarm), .critical_shutdown_pin(critical_shutdown_pin),
  .beta_comp_enable(beta_comp_enable), .filter_level_select(filter_level_select));

// ===== testbench/smbus_host_model.sv
// Host model: one-cycle read or write strobes on the register port.
// Assumes read data settles on the edge that takes the read.
`timescale 1ns/1ps
module smbus_host_model (
  input  wire logic       core_clk,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWdata,
  output logic            regWrite,
  output logic            regRead,
  input  wire logic [7:0] regRdata_ff
);
  initial begin
    regAddr  = 8'h00;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead  = 1'b0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= w;
    regRead  <= !w;
    @(posedge core_clk);
    regWrite <= 1'b0;
    regRead  <= 1'b0;
    // Released lines show the inverse so a stale value is never taken
    regAddr  <= ~a;
    regWdata <= ~d;
    #1 q = regRdata_ff;
  endtask
endmodule // smbus_host_model

// ===== testbench/tb.sv
// Testbench: register map, readings, limits, alarms and fan count.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
module tb;
  import thermal_limits_pkg::*;
  logic        core_clk = 1'b0, rst_n = 1'b0, convDone = 1'b0, tachIn = 1'b0, fastPwmClock = 1'b0;
  logic        extRes = 1'b0, critOverride = 1'b0, alarmClear = 1'b0, regWrite, regRead;
  logic [7:0]  regAddr, regWdata, regRdata_ff, rawDieTemp = 8'h00, q, lo;
  logic [12:0] rawRemoteTemp = 13'h0000;
  logic [13:0] cnt;
  logic [1:0]  pulse_edge_select = 2'h1, filter_level_select;
  logic        dieA, remA, lowA, critA, fanA, alertActive, sdPin, beta;
  int          fail_count = 0, tests_run = 0, tachHalf = 20, tachCnt = 0;
  logic [7:0]  rA [14] = '{8'h05, 8'h07, 8'h08, 8'h11, 8'h12, 8'h13, 8'h14, 8'h19, 8'h21, 8'h30, 8'h48, 8'h49, 8'hbf, 8'h02};
  logic [7:0]  rE [14] = '{8'h46, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h6e, 8'h0a, 8'h02, 8'hff, 8'hff, 8'h00, 8'h00};
  logic [7:0]  wA [10] = '{8'h05, 8'h13, 8'h14, 8'h12, 8'h12, 8'h30, 8'h30, 8'h48, 8'h19, 8'h19};
  logic [7:0]  wD [10] = '{8'h81, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff, 8'hfd, 8'h00, 8'h50, 8'h60};
  logic [7:0]  wE [10] = '{8'h81, 8'he0, 8'he0, 8'he0, 8'h00, 8'h02, 8'h00, 8'h03, 8'h50, 8'h50};

  initial forever #50 core_clk = ~core_clk;
  // Tach runs from the start so no saturated count ever raises a fan alarm
  always @(posedge core_clk) begin
    tachCnt <= (tachCnt >= tachHalf - 1) ? 0 : tachCnt + 1;
    if (tachCnt >= tachHalf - 1)
      tachIn <= ~tachIn;
  end

  smbus_host_model u_smbus_host_model (.core_clk(core_clk), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata_ff(regRdata_ff));
  thermal_readout_limit_registers u_thermal_readout_limit_registers (.core_clk(core_clk), .rst_n(rst_n),
    .clkEn(1'b1), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata_ff(regRdata_ff), .convDone(convDone), .rawDieTemp(rawDieTemp), .rawRemoteTemp(rawRemoteTemp),
    .tachIn(tachIn), .countTick(1'b1), .pulse_edge_select(pulse_edge_select), .fastPwmClock(fastPwmClock),
    .unsigned_format_select(1'b0), .extended_resolution_enable(extRes), .critOverride(critOverride),
    .alarmClear(alarmClear), .die_high_alarm(dieA), .remote_upper_alarm(remA), .remote_lower_alarm(lowA),
    .remote_critical_alarm(critA), .fanSlowAlarm(fanA), .alertActive(alertActive),
    .critical_shutdown_pin(sdPin), .beta_comp_enable(beta), .filter_level_select(filter_level_select));

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_smbus_host_model.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    u_smbus_host_model.xfer(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic conv(input logic [7:0] d, input logic [12:0] r);
    @(posedge core_clk);
    rawDieTemp    <= d;
    rawRemoteTemp <= r;
    convDone      <= 1'b1;
    @(posedge core_clk);
    convDone <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #(100 * 30000);
    fail_count++;
    print_verdict;
  end

  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 14; i++) rdc(rA[i], rE[i]);
    $display("reset values test done");
    for (int i = 0; i < 10; i++) begin
      wr(wA[i], wD[i]);
      rdc(wA[i], wE[i]);
    end
    for (int f = 0; f < 4; f++) begin
      wr(ADDR_FILTER_MODE, 8'(f << 1));
      chk("filter", 8'(f), {6'h00, filter_level_select});
    end
    rdc(ADDR_FILTER_MODE, 8'h06);
    $display("write test done");
    wr(ADDR_FILTER_MODE, 8'h00);
    conv(8'hf6, {8'h28, 3'b101, 2'b11});
    rdc(ADDR_LOCAL_TEMP, 8'hf6);
    rdc(ADDR_REM_SIGNED_HI, 8'h28);
    rdc(ADDR_REM_SIGNED_LO, 8'ha0);
    rdc(ADDR_REM_UNSIGNED_HI, 8'h28);
    rdc(ADDR_REM_UNSIGNED_LO, 8'ha0);
    wr(ADDR_REM_SIGNED_HI, 8'h00);
    rdc(ADDR_REM_SIGNED_HI, 8'h28);
    @(posedge core_clk) extRes <= 1'b1;
    wr(ADDR_FILTER_MODE, 8'h02);
    wr(ADDR_OFFSET_HI, 8'h02);
    conv(8'hf6, {8'h28, 3'b101, 2'b11});
    rdc(ADDR_REM_SIGNED_LO, 8'hb8);
    rdc(ADDR_REM_UNSIGNED_LO, 8'hb8);
    rdc(ADDR_REM_SIGNED_HI, 8'h2a);
    $display("reading test done");
    wr(ADDR_LOCAL_HIGH, 8'h46);
    @(posedge core_clk) critOverride <= 1'b1;
    wr(ADDR_CRIT_LIMIT, 8'h29);
    wr(ADDR_REM_HIGH_HI, 8'h1e);
    conv(8'h47, {8'h28, 5'h00});
    chk("die alarm", 8'h01, {7'h00, dieA});
    chk("remote alarm", 8'h01, {7'h00, remA});
    chk("crit alarm", 8'h01, {7'h00, critA});
    chk("shutdown", 8'h03, {6'h00, sdPin, alertActive});
    conv(8'h10, {8'h23, 5'h00});
    chk("shutdown held", 8'h01, {7'h00, sdPin});
    conv(8'h10, {8'h1c, 5'h00});
    chk("shutdown off", 8'h00, {7'h00, sdPin});
    @(posedge core_clk) alarmClear <= 1'b1;
    @(posedge core_clk) alarmClear <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("alarms cleared", 8'h00, {3'h0, dieA, remA, lowA, critA, alertActive});
    wr(ADDR_FILTER_MODE, 8'h01);
    conv(8'h50, {8'h1c, 5'h00});
    chk("cmp alert on", 8'h01, {7'h00, alertActive});
    conv(8'h10, {8'h1c, 5'h00});
    chk("cmp alert off", 8'h02, {6'h00, dieA, alertActive});
    $display("alarm test done");
    for (int m = 1; m < 5; m++) begin
      @(posedge core_clk);
      pulse_edge_select <= 2'(m == 4 ? 1 : m);
      fastPwmClock      <= (m == 4);
      repeat (400) @(posedge core_clk);
      u_smbus_host_model.xfer(1'b0, ADDR_FAN_COUNT_LO, 8'h00, lo);
      chk("edge bits", 8'(m == 4 ? 1 : m), {6'h00, lo[1:0]});
      tachHalf = 10;
      repeat (400) @(posedge core_clk);
      u_smbus_host_model.xfer(1'b0, ADDR_FAN_COUNT_HI, 8'h00, q);
      cnt = {q, lo[7:2]};
      // A 40-tick tach period scales to about 160 in every mode, 40 with fastPwmClock set
      chk("count", 8'h01, {7'h00, (m == 4) ? (cnt > 34 && cnt < 46) : (cnt > 150 && cnt < 166)});
      tachHalf = 20;
    end
    chk("fan alarm off", 8'h00, {7'h00, fanA});
    wr(ADDR_FAN_LIMIT_HI, 8'h00);
    repeat (400) @(posedge core_clk);
    chk("fan alarm on", 8'h01, {7'h00, fanA});
    $display("fan test done");
    @(posedge core_clk) rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rdc(ADDR_BETA_COMP, 8'h02);
    $display("second reset test done");
    print_verdict;
  end
endmodule // tb
